// ===== tlwu_top.sv
// Table access unit with long write to program memory
module tlwu_top #(
    parameter int DEPTH = tlwu_pkg::MEM_DEPTH
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    // Operations from the core
    input wire logic i_table_write_op,
    input wire logic i_latch_byte_write_op,
    input wire logic i_table_read_op,
    input wire logic i_latch_byte_read_op,
    input wire logic i_high_sel,
    input wire logic i_inc,
    input wire logic i_internal,
    input wire logic [tlwu_pkg::BYTE_W-1:0] i_wbyte,
    input wire logic i_ptr_load,
    input wire logic [tlwu_pkg::ADDR_W-1:0] i_ptr_value,
    // Interrupt state
    input wire logic i_global_irq_disable,
    input wire logic [tlwu_pkg::SRC_N-1:0] i_fast_en,
    input wire logic [tlwu_pkg::SRC_N-1:0] i_fast_flag,
    input wire logic i_periph_en,
    input wire logic i_periph_flag,
    input wire logic i_prog_voltage,
    // Results
    output logic O_HALT,
    output logic O_DONE,
    output logic O_VECTOR,
    output logic [tlwu_pkg::SRC_N-1:0] O_FLAG_CLR,
    output logic [tlwu_pkg::BYTE_W-1:0] O_RBYTE,
    output logic O_RBYTE_VALID,
    output logic [tlwu_pkg::WORD_W-1:0] O_LATCH,
    output logic [tlwu_pkg::ADDR_W-1:0] O_PTR
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------
    // Declarations
    // ------------------------------------------------
    tlwu_pkg::tlwu_state_t state;
    logic gdis_at_start;
    logic [tlwu_pkg::WORD_W-1:0] rdata;
    logic rd_pend;
    logic [tlwu_pkg::SRC_N-1:0] fast_hit;
    logic [tlwu_pkg::SRC_N-1:0] fast_pick;
    logic periph_hit;
    logic irq_hit;
    logic busy;
    logic mem_we;
    logic [tlwu_pkg::WORD_W-1:0] next_latch;

    assign busy = (state != tlwu_pkg::TLWU_IDLE);

    // ------------------------------------------------
    // Terminating sources
    // ------------------------------------------------
    // enable and flag
    assign fast_hit = i_fast_en & i_fast_flag;
    assign periph_hit = i_periph_en & i_periph_flag;
    assign irq_hit = (|fast_hit) | periph_hit;

    genvar g;
    generate
        for (g = 0; g < tlwu_pkg::SRC_N; g++) begin : g_pick
            if (g == 0) begin : g_first
                assign fast_pick[g] = fast_hit[g];
            end else begin : g_rest
                assign fast_pick[g] = fast_hit[g] & ~(|fast_hit[g-1:0]);
            end
        end
    endgenerate

    // ------------------------------------------------
    // Long write sequencer
    // ------------------------------------------------
    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            state <= tlwu_pkg::TLWU_IDLE;
            gdis_at_start <= 1'b0;
        end else begin
            unique case (state)
                tlwu_pkg::TLWU_IDLE: begin
                    if (i_table_write_op && i_internal) begin
                        state <= tlwu_pkg::TLWU_WRITE;
                        gdis_at_start <= i_global_irq_disable;
                    end
                end
                tlwu_pkg::TLWU_WRITE: begin
                    if (irq_hit) begin
                        state <= tlwu_pkg::TLWU_DONE;
                    end
                end
                tlwu_pkg::TLWU_DONE: begin
                    state <= tlwu_pkg::TLWU_IDLE;
                end
                default: begin
                    state <= tlwu_pkg::TLWU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            O_HALT <= 1'b0;
        end else if (state == tlwu_pkg::TLWU_IDLE) begin
            O_HALT <= i_table_write_op && i_internal;
        end else if (state == tlwu_pkg::TLWU_WRITE) begin
            O_HALT <= !irq_hit;
        end else begin
            O_HALT <= 1'b0;
        end
    end

    // Termination results: vector, flag clear
    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            O_DONE <= 1'b0;
            O_VECTOR <= 1'b0;
            O_FLAG_CLR <= '0;
        end else begin
            O_DONE <= (state == tlwu_pkg::TLWU_WRITE) && irq_hit;
            O_VECTOR <= (state == tlwu_pkg::TLWU_WRITE) && irq_hit && !gdis_at_start;
            O_FLAG_CLR <= (state == tlwu_pkg::TLWU_WRITE) ? fast_pick : '0;
        end
    end

    // ------------------------------------------------
    // Latch, pointer and memory
    // ------------------------------------------------
    // cells need voltage
    assign mem_we = (state == tlwu_pkg::TLWU_WRITE) && irq_hit && i_prog_voltage;

    always_comb begin
        next_latch = O_LATCH;
        if (!busy && (i_table_write_op || i_latch_byte_write_op)) begin
            if (i_high_sel) begin
                next_latch[tlwu_pkg::WORD_W-1:tlwu_pkg::HI_LSB] = i_wbyte;
            end else begin
                next_latch[tlwu_pkg::HI_LSB-1:0] = i_wbyte;
            end
        end else if (rd_pend) begin
            next_latch = rdata;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            O_LATCH <= tlwu_pkg::LATCH_RST;
            rd_pend <= 1'b0;
        end else begin
            O_LATCH <= next_latch;
            rd_pend <= !busy && i_table_read_op;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            O_PTR <= tlwu_pkg::PTR_RST;
        end else if (!busy && i_ptr_load) begin
            O_PTR <= i_ptr_value;
        end else if (state == tlwu_pkg::TLWU_DONE && i_inc) begin
            O_PTR <= O_PTR + 16'h0001;
        end else if (!busy && i_inc
                     && (i_table_read_op || (i_table_write_op && !i_internal))) begin
            O_PTR <= O_PTR + 16'h0001;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            O_RBYTE <= tlwu_pkg::BYTE_RST;
            O_RBYTE_VALID <= 1'b0;
        end else begin
            O_RBYTE_VALID <= !busy && i_latch_byte_read_op;
            if (!busy && i_latch_byte_read_op) begin
                O_RBYTE <= i_high_sel ? O_LATCH[tlwu_pkg::WORD_W-1:tlwu_pkg::HI_LSB]
                                      : O_LATCH[tlwu_pkg::HI_LSB-1:0];
            end
        end
    end

    tlwu_mem #(.DEPTH(DEPTH)) u_mem (
        .i_clk(I_MCLK),
        .i_we(mem_we),
        .i_waddr(O_PTR[AW-1:0]),
        .i_wdata(O_LATCH),
        .i_re(!busy && i_table_read_op),
        .i_raddr(O_PTR[AW-1:0]),
        .o_rdata(rdata)
    );

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    property p_halt_start;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state == tlwu_pkg::TLWU_IDLE && i_table_write_op && i_internal) |=> O_HALT;
    endproperty
    a_halt_start: assert property (p_halt_start) else $error("no halt on long write");

    property p_hold;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state == tlwu_pkg::TLWU_WRITE && !irq_hit) |=> state == tlwu_pkg::TLWU_WRITE;
    endproperty
    a_hold: assert property (p_hold) else $error("long write ended without cause");

    property p_need_both;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        $rose(O_DONE)
            |-> $past((|(i_fast_en & i_fast_flag)) | (i_periph_en & i_periph_flag));
    endproperty
    a_need_both: assert property (p_need_both) else $error("done without enabled flag");

    property p_one_clr;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        $onehot0(O_FLAG_CLR) && (!(|O_FLAG_CLR) || O_DONE);
    endproperty
    a_one_clr: assert property (p_one_clr) else $error("bad flag clear");

    property p_periph_keep;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state == tlwu_pkg::TLWU_WRITE && periph_hit && !(|fast_hit)) |=> O_FLAG_CLR == '0;
    endproperty
    a_periph_keep: assert property (p_periph_keep) else $error("peripheral flag cleared");

    property p_no_vec;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (O_DONE && gdis_at_start) |-> !O_VECTOR;
    endproperty
    a_no_vec: assert property (p_no_vec) else $error("vectored while disabled");

    property p_inc;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (!busy && i_table_read_op && i_inc && !i_ptr_load) |=> O_PTR == $past(O_PTR) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("pointer not incremented");

    property p_novolt;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        mem_we |-> i_prog_voltage;
    endproperty
    a_novolt: assert property (p_novolt) else $error("write without voltage");

    property p_lbw;
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state == tlwu_pkg::TLWU_IDLE && i_latch_byte_write_op && !i_table_write_op)
            |=> !O_HALT;
    endproperty
    a_lbw: assert property (p_lbw) else $error("latch write halted core");

    c_vec: cover property (@(posedge I_MCLK) disable iff (!I_RSTN) O_VECTOR);
    c_seq: cover property (@(posedge I_MCLK) disable iff (!I_RSTN) O_DONE && !O_VECTOR);
    c_rd: cover property (@(posedge I_MCLK) disable iff (!I_RSTN) O_RBYTE_VALID);
endmodule : tlwu_top

// ===== tlwu_pkg.sv
// Package: constants and types of the table long write unit
package tlwu_pkg;
    localparam int ADDR_W = 16;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int MEM_DEPTH = 1024;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] LATCH_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam int HI_LSB = 8;
    // Programming pulse width bounds in ns, for the controlling code
    localparam int PULSE_MIN_NS = 10000;
    localparam int PULSE_MAX_NS = 1000000;
    localparam int CLK_NS = 4;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;
    // Fast interrupt sources, highest priority first
    localparam int SRC_N = 3;
    localparam int SRC_PIN = 0;
    localparam int SRC_TMR = 1;
    localparam int SRC_CNT = 2;
    typedef enum logic [2:0] {
        TLWU_IDLE  = 3'b001,
        TLWU_WRITE = 3'b010,
        TLWU_DONE  = 3'b100
    } tlwu_state_t;
endpackage : tlwu_pkg

// ===== tlwu_mem.sv
// Program memory array with registered read data
module tlwu_mem #(
    parameter int DEPTH = tlwu_pkg::MEM_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock
    input wire logic i_clk,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [tlwu_pkg::WORD_W-1:0] i_wdata,
    // Read port
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [tlwu_pkg::WORD_W-1:0] o_rdata
);
    logic [tlwu_pkg::WORD_W-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : tlwu_mem

// ===== tlwu_irq_model.sv
// Interrupt flag model standing beside the table unit
module tlwu_irq_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Flag events
    input wire logic [tlwu_pkg::SRC_N-1:0] i_set,
    input wire logic [tlwu_pkg::SRC_N-1:0] i_clr,
    // Flags to the unit
    output logic [tlwu_pkg::SRC_N-1:0] o_flag
);
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_flag <= '0;
        end else begin
            // New event wins over a clear in the same cycle
            o_flag <= (o_flag & ~i_clr) | i_set;
        end
    end
endmodule : tlwu_irq_model

// ===== tlwu_top_tb.sv
// Self-checking bench of the table long write unit
module tlwu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] TW = 4'h1;
    localparam logic [3:0] LW = 4'h2;
    localparam logic [3:0] TR = 4'h4;
    localparam logic [3:0] BR = 4'h8;
    typedef struct packed {
        logic [3:0] k;
        logic hi;
        logic [7:0] b;
        logic [15:0] e;
    } tlwu_row_t;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [3:0] ops = 4'h0;
    logic hi = 1'h0;
    logic inc = 1'h0;
    logic intl = 1'h1;
    logic [7:0] wb = 8'h00;
    logic pl = 1'h0;
    logic [15:0] pv = 16'h0000;
    logic gid = 1'h0;
    logic [2:0] fen = 3'h0;
    logic [2:0] set = 3'h0;
    logic [2:0] flag;
    logic pen = 1'h0;
    logic pfl = 1'h0;
    logic volt = 1'h1;
    logic halt, done, vec, rbv;
    logic [2:0] fclr;
    logic [7:0] rb;
    logic [15:0] lat, ptr;
    int errors = 0;
    int cmp_count = 0;
    tlwu_row_t rows [5] = '{'{LW, 1'h0, 8'h34, 16'h0034}, '{LW, 1'h1, 8'hff, 16'hff34},
        '{LW, 1'h1, 8'h12, 16'h1234}, '{BR, 1'h1, 8'h00, 16'h0112},
        '{BR, 1'h0, 8'h00, 16'h0134}};

    always #2 clk = ~clk;

    tlwu_top DUT (.I_MCLK(clk), .I_RSTN(rstn), .i_table_write_op(ops[0]),
        .i_latch_byte_write_op(ops[1]), .i_table_read_op(ops[2]),
        .i_latch_byte_read_op(ops[3]), .i_high_sel(hi), .i_inc(inc), .i_internal(intl),
        .i_wbyte(wb), .i_ptr_load(pl), .i_ptr_value(pv), .i_global_irq_disable(gid),
        .i_fast_en(fen), .i_fast_flag(flag), .i_periph_en(pen), .i_periph_flag(pfl),
        .i_prog_voltage(volt), .O_HALT(halt), .O_DONE(done), .O_VECTOR(vec),
        .O_FLAG_CLR(fclr), .O_RBYTE(rb), .O_RBYTE_VALID(rbv), .O_LATCH(lat), .O_PTR(ptr));

    tlwu_irq_model irq (.i_clk(clk), .i_rstn(rstn), .i_set(set), .i_clr(fclr), .o_flag(flag));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic do_op(input logic [3:0] k, input logic h, input logic [7:0] b);
        @(posedge clk);
        ops <= k;
        hi <= h;
        wb <= b;
        @(posedge clk);
        ops <= 4'h0;
    endtask : do_op

    task automatic set_ptr(input logic [15:0] v);
        @(posedge clk);
        pl <= 1'h1;
        pv <= v;
        @(posedge clk);
        pl <= 1'h0;
        #1;
        check("ptr_load", ptr, v);
    endtask : set_ptr

    task automatic long_write(input logic h, input logic [7:0] b, input logic [2:0] fs,
            input logic pf, input logic [15:0] e);
        int n;
        logic [2:0] f0;
        n = 0;
        // Flags left standing by earlier tests
        f0 = flag;
        do_op(TW, h, b);
        #1;
        check("halt_start", 16'(halt), 16'h0001);
        // Pulse held for the minimum width
        repeat (tlwu_pkg::PULSE_MIN_CYC) @(posedge clk);
        set <= 3'h4;
        @(posedge clk);
        set <= 3'h0;
        repeat (3) @(posedge clk);
        #1;
        check("halt_unenabled", 16'(halt), 16'h0001);
        @(posedge clk);
        set <= fs;
        pfl <= pf;
        @(posedge clk);
        set <= 3'h0;
        #1;
        while (done !== 1'h1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("done", 16'(done), 16'h0001);
        check("halt_end", 16'(halt), 16'h0000);
        check("vec_clr", 16'({vec, fclr}), e);
        @(posedge clk);
        pfl <= 1'h0;
        #1;
        check("flags", 16'(flag), 16'((f0 | 3'h4 | fs) & ~e[2:0]));
    endtask : long_write

    // ----------------------------------------
    // Watchdog and main sequence
    // ----------------------------------------
    initial begin
        #60000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        #1;
        check("reset", {halt, done, vec, rbv, lat[11:0]}, 16'h0000);
        $display("Test reset values done");
        @(posedge clk);
        rstn <= 1'h1;
        foreach (rows[i]) begin
            do_op(rows[i].k, rows[i].hi, rows[i].b);
            #1;
            check("row", (rows[i].k == BR) ? {7'h0, rbv, rb} : lat, rows[i].e);
            check("row_halt", 16'(halt), 16'h0000);
        end
        $display("Test latch rows done");
        set_ptr(16'h0005);
        @(posedge clk);
        fen <= 3'h3;
        inc <= 1'h1;
        long_write(1'h1, 8'hab, 3'h3, 1'h0, 16'h0009);
        check("latch_hi", lat, 16'hab34);
        check("ptr_inc", ptr, 16'h0006);
        $display("Test pin flag end done");
        @(posedge clk);
        inc <= 1'h0;
        volt <= 1'h0;
        gid <= 1'h1;
        fen <= 3'h0;
        pen <= 1'h1;
        set_ptr(16'h0005);
        long_write(1'h0, 8'h00, 3'h0, 1'h1, 16'h0000);
        check("latch_lo", lat, 16'hab00);
        check("ptr_kept", ptr, 16'h0005);
        $display("Test peripheral end done");
        @(posedge clk);
        inc <= 1'h1;
        do_op(TR, 1'h0, 8'h00);
        @(posedge clk);
        #1;
        check("read_word", lat, 16'hab34);
        check("read_ptr", ptr, 16'h0006);
        do_op(BR, 1'h1, 8'h00);
        #1;
        check("read_byte", {7'h0, rbv, rb}, 16'h01ab);
        $display("Test table read done");
        // External target: latch and pointer only, no halt
        @(posedge clk);
        intl <= 1'h0;
        do_op(TW, 1'h0, 8'h5a);
        #1;
        check("ext_halt", 16'(halt), 16'h0000);
        check("ext_latch", lat, 16'hab5a);
        check("ext_ptr", ptr, 16'h0007);
        @(posedge clk);
        intl <= 1'h1;
        $display("Test external write done");
        do_op(TW, 1'h0, 8'h00);
        #1;
        check("halt_again", 16'(halt), 16'h0001);
        @(posedge clk);
        rstn <= 1'h0;
        @(posedge clk);
        rstn <= 1'h1;
        #1;
        check("reset_abort", {halt, done, lat[13:0]}, 16'h0000);
        check("reset_ptr", ptr, 16'h0000);
        $display("Test reset abort done");
        stop_test();
    end
endmodule : tlwu_top_tb
